// File: pa_bias_servo_control.v
// bias servo core: wiper counter, hold detection, shutdown gating and byte registers
`timescale 1ns/10ps
`include "bias_servo_defs.vh"
module pa_bias_servo_control (
  input wire clk_sys,
  input wire reset,
  input wire serial_clock,
  input wire serial_data,
  input wire loop_select,
  input wire direction_signal,
  input wire output_off_input,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire bus_stop,
  output reg [7:0] reg_rdata,
  output reg [7:0] gate_code,
  output reg [5:0] reference_code,
  output reg gate_drive_enable,
  output reg wiper_hold_state,
  output reg gain_select_bit,
  output reg nv_write_latch,
  output reg nv_commit,
  output reg [7:0] nv_gate_code,
  output reg [5:0] nv_reference_code,
  output reg nv_gain
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  wire clk_s;
  wire data_s;
  wire sel_s;
  wire dir_s;
  wire off_s;

  // all pin inputs cross two flops before any logic reads them
  // the serial clock is sampled like any pin; its falling edges become one-cycle enables
  pin_sync u_sync_clk (.clk_sys(clk_sys), .reset(reset), .async_in(serial_clock), .sync_out(clk_s));
  pin_sync u_sync_data (.clk_sys(clk_sys), .reset(reset), .async_in(serial_data), .sync_out(data_s));
  pin_sync u_sync_sel (.clk_sys(clk_sys), .reset(reset), .async_in(loop_select), .sync_out(sel_s));
  pin_sync u_sync_dir (.clk_sys(clk_sys), .reset(reset), .async_in(direction_signal), .sync_out(dir_s));
  pin_sync u_sync_off (.clk_sys(clk_sys), .reset(reset), .async_in(output_off_input), .sync_out(off_s));

  // ****************************************
  // edge detection
  // ****************************************
  reg clk_d;
  reg dir_d;
  reg sel_d;
  wire clk_fall;
  wire dir_edge;
  wire sel_rise;

  // previous sampled levels, used only for edge finding
  always @(posedge clk_sys) begin
    if (reset) begin
      clk_d <= 1'b0;
      dir_d <= 1'b0;
      sel_d <= 1'b0;
    end else begin
      clk_d <= clk_s;
      dir_d <= dir_s;
      sel_d <= sel_s;
    end
  end

  // ****************************************
  // settling after reset
  // ****************************************
  // the synchronisers and edge flops all come out of reset at zero, so a pin
  // that rests high would look like a rising edge two cycles later; edges are
  // masked until the pipeline holds real pin levels
  reg [1:0] settle_cnt;
  wire settled;

  always @(posedge clk_sys) begin
    if (reset) begin
      settle_cnt <= `SYNC_SETTLE_CYCLES;
    end else if (settle_cnt != 2'h0) begin
      settle_cnt <= settle_cnt - 2'h1;
    end
  end

  assign settled = (settle_cnt == 2'h0);

  // edges are one-cycle pulses on the system clock
  assign clk_fall = settled & clk_d & ~clk_s;
  assign dir_edge = settled & (dir_d ^ dir_s);
  assign sel_rise = settled & sel_s & ~sel_d;

  // ****************************************
  // shutdown arming
  // ****************************************
  // after shutdown the loop stays disarmed until select rises again,
  // so a select left high through shutdown cannot move the wiper
  reg armed;

  always @(posedge clk_sys) begin
    if (reset) begin
      armed <= 1'b1;
    end else begin
      if (off_s) begin
        armed <= 1'b0;
      end else if (sel_rise) begin
        armed <= 1'b1;
      end
    end
  end

  // ****************************************
  // closed loop enable
  // ****************************************
  wire link_ready;
  wire loop_active;

  // a low data line means a bus transfer is in flight, so stepping waits for it
  assign link_ready = sel_s & data_s;
  // stepping also needs no shutdown and an armed loop
  assign loop_active = link_ready & armed & ~off_s;

  // ****************************************
  // register write decode
  // ****************************************
  wire wr_gate;
  wire wr_ref;
  wire wr_status;
  wire status_clean;

  // single byte access, each register at its own address
  // reserved bytes 0x02 to 0x0e and unmapped bytes take no write at all
  assign wr_gate = reg_write & (reg_addr == `ADDR_GATE_CODE);
  assign wr_ref = reg_write & (reg_addr == `ADDR_REF_CODE);
  assign wr_status = reg_write & (reg_addr == `ADDR_STATUS);
  // latch changes only when the other status bits are written zero
  assign status_clean = (reg_wdata & ~(8'h01 << `ST_WRITE_LATCH)) == `ST_WRITE_LATCH_CLR;

  // ****************************************
  // wiper counter and hold state
  // ****************************************
  reg [7:0] next_gate_code;
  reg next_hold;

  // one tap per falling serial clock edge, saturating at both ends;
  // a gate code write overrides the counter in the same cycle
  // a step lands about three system cycles after the falling pin edge
  always @* begin
    next_gate_code = gate_code;
    next_hold = wiper_hold_state;
    if (wr_gate) begin
      next_gate_code = reg_wdata;
      next_hold = 1'b0;
    end else if (sel_rise) begin
      // a new calibration pass leaves hold; tested ahead of the loop branch,
      // since select high already makes the loop active in this cycle;
      // a falling clock in that same cycle is skipped
      next_hold = 1'b0;
    end else if (loop_active) begin
      if (dir_edge) begin
        next_hold = 1'b1;
      end else if (clk_fall && !wiper_hold_state) begin
        if (dir_s) begin
          if (gate_code != `GATE_CODE_MAX) begin
            next_gate_code = gate_code + 8'h01;
          end
        end else begin
          if (gate_code != `GATE_CODE_MIN) begin
            next_gate_code = gate_code - 8'h01;
          end
        end
      end
    end
  end

  // hysteresis lives in the comparator; hold prevents small direction flicker
  // from walking the code once lock is reached; shutdown leaves the code alone,
  // so the previous bias returns as soon as shutdown ends
  always @(posedge clk_sys) begin
    if (reset) begin
      gate_code <= `GATE_CODE_DEFAULT;
      wiper_hold_state <= 1'b0;
    end else begin
      gate_code <= next_gate_code;
      wiper_hold_state <= next_hold;
    end
  end

  // ****************************************
  // reference code, gain and write latch
  // ****************************************
  // every status write sets the gain; only a clean one may move the latch
  always @(posedge clk_sys) begin
    if (reset) begin
      reference_code <= `REF_CODE_DEFAULT;
      gain_select_bit <= `GAIN_DEFAULT;
      nv_write_latch <= 1'b0;
    end else begin
      if (wr_ref) begin
        reference_code <= reg_wdata[5:0];
      end
      if (wr_status) begin
        gain_select_bit <= reg_wdata[`ST_GAIN];
        if (status_clean) begin
          nv_write_latch <= reg_wdata[`ST_WRITE_LATCH];
        end
      end
    end
  end

  // ****************************************
  // nonvolatile commit
  // ****************************************
  // a write seen while the latch is set is committed at the following stop;
  // the shadow copy stands for the saved storage, and a block reset counts as
  // power-up with the factory contents, which are the reset defaults
  reg commit_pending;
  wire any_write;
  wire latch_clear;

  // the write that drops the latch is itself volatile and ends any waiting save
  assign any_write = wr_gate | wr_ref | wr_status;
  assign latch_clear = wr_status & status_clean & ~reg_wdata[`ST_WRITE_LATCH];

  always @(posedge clk_sys) begin
    if (reset) begin
      commit_pending <= 1'b0;
      nv_commit <= 1'b0;
    end else begin
      nv_commit <= 1'b0;
      if (latch_clear) begin
        commit_pending <= 1'b0;
      end else if (any_write && nv_write_latch) begin
        commit_pending <= 1'b1;
      end else if (bus_stop && commit_pending) begin
        commit_pending <= 1'b0;
        nv_commit <= 1'b1;
      end
    end
  end

  // shadow registers hold what a power-up would recall; the copies come
  // from the live registers one cycle after the commit pulse
  always @(posedge clk_sys) begin
    if (reset) begin
      nv_gate_code <= `GATE_CODE_DEFAULT;
      nv_reference_code <= `REF_CODE_DEFAULT;
      nv_gain <= `GAIN_DEFAULT;
    end else if (nv_commit) begin
      nv_gate_code <= gate_code;
      nv_reference_code <= reference_code;
      nv_gain <= gain_select_bit;
    end
  end

  // ****************************************
  // gate drive output
  // ****************************************
  // registered so the pin cannot glitch; it is low through reset, rises on the first cycle after it, and drops
  // three cycles after the shutdown pin rises, once the pin has crossed the synchroniser
  always @(posedge clk_sys) begin
    if (reset) begin
      gate_drive_enable <= 1'b0;
    end else begin
      gate_drive_enable <= ~off_s;
    end
  end

  // ****************************************
  // register read path
  // ****************************************
  reg [7:0] status_view;
  reg [7:0] next_rdata;

  // status bits 7, 6 and 4 mirror the synchronised pins; test bits 5, 3 and 2 read zero
  always @* begin
    status_view = 8'h00;
    status_view[`ST_SHUTDOWN] = off_s;
    status_view[`ST_DIRECTION] = dir_s;
    status_view[`ST_SELECT] = sel_s;
    status_view[`ST_WRITE_LATCH] = nv_write_latch;
    status_view[`ST_GAIN] = gain_select_bit;
  end

  // byte select by address
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `ADDR_GATE_CODE: begin
        next_rdata = gate_code;
      end
      `ADDR_REF_CODE: begin
        next_rdata = {2'b00, reference_code};
      end
      `ADDR_STATUS: begin
        next_rdata = status_view;
      end
      default: begin
        // reserved and unmapped bytes read zero
        next_rdata = 8'h00;
      end
    endcase
  end

  // read data is registered one cycle after the read strobe
  // and holds between reads, so the host may take it at any later cycle
  always @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// File: bias_servo_defs.vh
// constants for the bias servo block: register map, status fields and reset values
`ifndef BIAS_SERVO_DEFS_VH
`define BIAS_SERVO_DEFS_VH
// ****************************************
// register byte addresses
// ****************************************
`define ADDR_GATE_CODE 8'h00
`define ADDR_REF_CODE 8'h01
`define ADDR_STATUS 8'h0f
// ****************************************
// status byte bit positions
// ****************************************
`define ST_SHUTDOWN 7
`define ST_DIRECTION 6
`define ST_SELECT 4
`define ST_WRITE_LATCH 1
`define ST_GAIN 0
`define ST_WRITE_LATCH_SET 8'h02
`define ST_WRITE_LATCH_CLR 8'h00
// ****************************************
// reset and power-up values
// ****************************************
`define GATE_CODE_DEFAULT 8'h00
`define REF_CODE_DEFAULT 6'h00
`define GAIN_DEFAULT 1'b0
`define GATE_CODE_MAX 8'hff
`define GATE_CODE_MIN 8'h00
`define REF_CODE_MASK 8'h3f
// ****************************************
// timing counts
// ****************************************
`define SYNC_SETTLE_CYCLES 2'h3
`endif

// File: pin_sync.v
// two-flop synchroniser for one level crossing into the system clock
`timescale 1ns/10ps
module pin_sync (
  input wire clk_sys,
  input wire reset,
  input wire async_in,
  output reg sync_out
);
  reg stage_a;

  // first stage feeds only the second stage
  always @(posedge clk_sys) begin
    if (reset) begin
      stage_a <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage_a <= async_in;
      sync_out <= stage_a;
    end
  end
endmodule

// File: bias_host_model.sv
// host controller model: drives loop select, serial data and the serial clock
`timescale 1ns/10ps
module bias_host_model (
  input wire clk_sys,
  output logic serial_clock,
  output logic serial_data,
  output logic loop_select
);
  // ****************************************
  // idle levels
  // ****************************************
  // clock stands low between frames; data line rests at its pull-up level
  initial begin
    serial_clock = 1'b0;
    serial_data = 1'b1;
    loop_select = 1'b0;
  end

  // one frame of n clock pulses at 320 ns, data held at d throughout
  task automatic clocks(input int n, input logic d);
    @(posedge clk_sys);
    serial_data <= d;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk_sys);
      serial_clock <= 1'b1;
      repeat (4) @(posedge clk_sys);
      serial_clock <= 1'b0;
    end
    // let the last falling edge clear the synchronisers
    repeat (6) @(posedge clk_sys);
    serial_data <= 1'b1;
    #1;
  endtask

  // select gates adjustment; dropping it stands for rf being present
  task automatic sel(input logic v);
    @(posedge clk_sys);
    loop_select <= v;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask
endmodule

// File: bias_servo_checker_asserts.sv
// checker for the bias servo block, bound to its top module
`timescale 1ns/10ps
module bias_servo_checker (
  input wire clk_sys,
  input wire reset,
  input wire loop_select,
  input wire output_off_input,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire bus_stop,
  input wire [7:0] reg_rdata,
  input wire [7:0] gate_code,
  input wire gate_drive_enable,
  input wire wiper_hold_state,
  input wire gain_select_bit,
  input wire nv_write_latch,
  input wire nv_commit,
  input wire [7:0] nv_gate_code
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic clr_req;
  // marks a clearing status write, so a latch drop can be traced to it
  always @(posedge clk_sys) clr_req <= reg_write && reg_addr == 8'h0f && reg_wdata == 8'h00;

  // ****************************************
  // wiper and output
  // ****************************************
  drive_off_a: assert property (output_off_input [*5] |-> !gate_drive_enable)
    else $error("gate drive not off in shutdown");
  one_tap_a: assert property (!reg_write |=> gate_code == $past(gate_code) ||
    gate_code == $past(gate_code) + 8'h01 || gate_code == $past(gate_code) - 8'h01)
    else $error("wiper moved more than one tap");
  top_sat_a: assert property (gate_code == 8'hff && !reg_write |=> gate_code != 8'h00)
    else $error("wiper wrapped at top");
  open_loop_a: assert property (!loop_select [*5] ##0 !reg_write |=> $stable(gate_code))
    else $error("wiper moved in open loop");
  hold_keep_a: assert property (wiper_hold_state && $past(wiper_hold_state) && !$past(reg_write)
    |-> $stable(gate_code)) else $error("wiper moved while held");
  gate_write_a: assert property (reg_write && reg_addr == 8'h00 |=> gate_code == $past(reg_wdata))
    else $error("gate code write lost");
  // ****************************************
  // status byte and nonvolatile commit
  // ****************************************
  status_low_a: assert property (reg_read && reg_addr == 8'h0f |=>
    reg_rdata[1:0] == {$past(nv_write_latch), $past(gain_select_bit)}) else $error("status low bits wrong");
  off_flag_a: assert property (output_off_input [*5] ##0 (reg_read && reg_addr == 8'h0f) |=> reg_rdata[7])
    else $error("shutdown flag not read");
  latch_set_a: assert property (reg_write && reg_addr == 8'h0f && reg_wdata == 8'h02 |=> nv_write_latch)
    else $error("write latch not set");
  latch_keep_a: assert property ($fell(nv_write_latch) |-> clr_req)
    else $error("write latch dropped without clear");
  commit_a: assert property (nv_commit |-> $past(bus_stop) ##1 !nv_commit)
    else $error("commit pulse wrong");
  nv_copy_a: assert property ($changed(nv_gate_code) |-> $past(nv_commit))
    else $error("saved code changed without commit");
endmodule

bind pa_bias_servo_control bias_servo_checker chk (.clk_sys(clk_sys), .reset(reset), .loop_select(loop_select),
  .output_off_input(output_off_input), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .bus_stop(bus_stop), .reg_rdata(reg_rdata), .gate_code(gate_code),
  .gate_drive_enable(gate_drive_enable), .wiper_hold_state(wiper_hold_state), .gain_select_bit(gain_select_bit),
  .nv_write_latch(nv_write_latch), .nv_commit(nv_commit), .nv_gate_code(nv_gate_code));

// File: pa_bias_servo_control_tb.sv
// testbench for the bias servo block: register accesses and link pulses
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module pa_bias_servo_control_tb;
  logic clk_sys, reset, reg_write, reg_read, bus_stop, direction_signal, output_off_input;
  logic [7:0] reg_addr, reg_wdata;
  wire serial_clock, serial_data, loop_select, gate_drive_enable, wiper_hold_state;
  wire gain_select_bit, nv_write_latch, nv_commit;
  wire [7:0] reg_rdata, gate_code, nv_gate_code;
  wire [5:0] reference_code, nv_reference_code;
  wire nv_gain;
  int error_cnt = 0;
  int compares = 0;

  pa_bias_servo_control dut (.clk_sys(clk_sys), .reset(reset), .serial_clock(serial_clock),
    .serial_data(serial_data), .loop_select(loop_select), .direction_signal(direction_signal),
    .output_off_input(output_off_input), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .bus_stop(bus_stop), .reg_rdata(reg_rdata), .gate_code(gate_code),
    .reference_code(reference_code), .gate_drive_enable(gate_drive_enable), .wiper_hold_state(wiper_hold_state),
    .gain_select_bit(gain_select_bit), .nv_write_latch(nv_write_latch), .nv_commit(nv_commit),
    .nv_gate_code(nv_gate_code), .nv_reference_code(nv_reference_code), .nv_gain(nv_gain));
  bias_host_model host (.clk_sys(clk_sys), .serial_clock(serial_clock), .serial_data(serial_data),
    .loop_select(loop_select));

  // ****************************************
  // access tasks
  // ****************************************
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    wt(1);
    reg_write <= 1'b0;
  endtask
  // read data is registered, so it is sampled one edge after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    wt(1);
    reg_read <= 1'b0;
    `CHK("rdata", e, reg_rdata)
  endtask
  task automatic stop();
    @(posedge clk_sys);
    bus_stop <= 1'b1;
    @(posedge clk_sys);
    bus_stop <= 1'b0;
    wt(3);
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // a hang ends the run as a mismatch
  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {reset, reg_write, reg_read, bus_stop, direction_signal, output_off_input} = 6'h20;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    wt(10);
    reset <= 1'b0;
    wt(2);
    rd(8'h0f, 8'h00);
    rd(8'h00, 8'h00);
    rd(8'h05, 8'h00);
    wr(8'h01, 8'hff);
    `CHK("ref", 6'h3f, reference_code)
    $display("test reset_map done");
    direction_signal <= 1'b1;
    host.sel(1'b1);
    wr(8'h00, 8'hfd);
    rd(8'h0f, 8'h50);
    host.clocks(2, 1'b0);
    `CHK("gate", 8'hfd, gate_code)
    host.clocks(5, 1'b1);
    `CHK("gate", 8'hff, gate_code)
    direction_signal <= 1'b0;
    wt(6);
    `CHK("hold", 1'b1, wiper_hold_state)
    host.clocks(2, 1'b1);
    `CHK("gate", 8'hff, gate_code)
    wr(8'h00, 8'h02);
    host.clocks(4, 1'b1);
    `CHK("gate", 8'h00, gate_code)
    $display("test stepping done");
    host.sel(1'b0);
    wr(8'h00, 8'h10);
    host.clocks(3, 1'b1);
    `CHK("gate", 8'h10, gate_code)
    rd(8'h0f, 8'h00);
    output_off_input <= 1'b1;
    wt(6);
    `CHK("drive", 1'b0, gate_drive_enable)
    rd(8'h0f, 8'h80);
    host.sel(1'b1);
    host.clocks(2, 1'b1);
    `CHK("gate", 8'h10, gate_code)
    output_off_input <= 1'b0;
    wt(6);
    `CHK("drive", 1'b1, gate_drive_enable)
    host.clocks(2, 1'b1);
    `CHK("gate", 8'h10, gate_code)
    host.sel(1'b0);
    host.sel(1'b1);
    host.clocks(2, 1'b1);
    `CHK("gate", 8'h0e, gate_code)
    $display("test loop_shutdown done");
    wr(8'h0f, 8'h02);
    `CHK("latch", 1'b1, nv_write_latch)
    rd(8'h0f, 8'h12);
    wr(8'h0f, 8'h01);
    `CHK("latch", 1'b1, nv_write_latch)
    `CHK("gain", 1'b1, gain_select_bit)
    wr(8'h00, 8'h5a);
    stop();
    `CHK("saved", 8'h5a, nv_gate_code)
    `CHK("saved_ref", 6'h3f, nv_reference_code)
    `CHK("saved_gain", 1'b1, nv_gain)
    wr(8'h0f, 8'h00);
    `CHK("latch", 1'b0, nv_write_latch)
    wr(8'h00, 8'h33);
    stop();
    `CHK("saved", 8'h5a, nv_gate_code)
    rd(8'h00, 8'h33);
    $display("test nv_store done");
    end_of_test();
  end
endmodule
